/* File: pkg/hub_port_cfg_defs.vh */
// Constants for the hub port disable and power configuration block
`ifndef HUB_PORT_CFG_DEFS_VH
`define HUB_PORT_CFG_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_CFG_BYTE3 8'h08
`define OFS_NON_REMOVABLE 8'h09
`define OFS_SELF_PWR_MASK 8'h0a
`define OFS_BUS_PWR_MASK 8'h0b
`define OFS_SELF_PWR_BUDGET 8'h0c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_REMAP_EN 3
`define BIT_COMPOUND 3
`define PORT_LO 1
`define PORT_HI 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_CFG_BYTE3 8'h00
`define RST_MASK 8'h00
`define RST_BUDGET 8'h32
`define RST_NON_REMOVABLE 8'h00

`endif

/* File: src/hub_port_disable_power_config.v */
// Port disable masks, power budget and port numbering for the hub
//
// Functional notes
// - The self-powered mask has eight bits and a set bit disables a port.
// - Mask bits 1 to 4 drive ports 1 to 4; bits 0 and 5 to 7 are spare.
// - The masks act only while the remap enable bit is zero.
// - A disabled port stays unavailable and cannot be enabled by the host.
// - The reported port count equals the number of ports left enabled.
// - Remaining ports are numbered contiguously from one.
// - In the default configuration the strap pins choose disabled ports.
// - The bus-powered mask uses the same encoding and strap defaults.
// - The self-powered budget is eight bits in steps of 2 mA.
// - Bit 3 of configuration byte 3 is the remap enable.
// - The compound flag is reported and needs non-removable ports.
`include "hub_port_cfg_defs.vh"

module hub_port_disable_power_config #(
    parameter NPORT = 4
) (
    // Clock, reset, enable
    input wire CLK_SYS_I,
    input wire RESETN_I,
    input wire CLK_EN_I,
    // Configuration register port
    input wire [7:0] CFG_ADDR_I,
    input wire CFG_WR_I,
    input wire [7:0] CFG_WDATA_I,
    output reg [7:0] CFG_RDATA_O,
    // Default configuration select and straps
    input wire USE_DEFAULT_I,
    input wire [NPORT:1] STRAP_POS_I,
    input wire [NPORT:1] STRAP_NEG_I,
    // Power mode, 1 = self-powered
    input wire SELF_POWERED_I,
    // Results toward the hub core
    output reg [NPORT:1] PORT_ENABLED_O,
    output reg [2:0] PORT_COUNT_O,
    output reg [3*NPORT-1:0] PORT_LOGICAL_O,
    output reg [7:0] CURRENT_BUDGET_O,
    output reg COMPOUND_O,
    output reg REMAP_ACTIVE_O
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    reg [2*NPORT:0] sync1_reg, sync2_reg, sync3_reg;
    reg [2*NPORT:0] pins_reg;
    wire [2*NPORT:0] pins_raw;
    wire [2*NPORT:0] pins_next;
    assign pins_raw = {SELF_POWERED_I, STRAP_NEG_I, STRAP_POS_I};

    // Per-pin agreement filter; a level seen by only one of the last
    // two stages may be settling debris, so the old level is kept
    genvar g;
    generate
        for (g = 0; g <= 2*NPORT; g = g + 1) begin : g_pin_filter
            assign pins_next[g] = (sync2_reg[g] == sync3_reg[g]) ?
                                  sync3_reg[g] : pins_reg[g];
        end
    endgenerate

    // Three stages; a level is taken once stages two and three agree
    // Reset level is low for every pin, so a held pin shows after a while
    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            sync1_reg <= {(2*NPORT+1){1'b0}};
            sync2_reg <= {(2*NPORT+1){1'b0}};
            sync3_reg <= {(2*NPORT+1){1'b0}};
            pins_reg <= {(2*NPORT+1){1'b0}};
        end else if (CLK_EN_I) begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pins_reg <= pins_next;
        end
    end

    // Filtered levels; a pin change takes five edges to reach the outputs
    wire [NPORT:1] strap_pos = pins_reg[NPORT-1:0];
    wire [NPORT:1] strap_neg = pins_reg[2*NPORT-1:NPORT];
    wire self_pwr = pins_reg[2*NPORT];

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Full bytes kept, so software reads back exactly what it wrote
    reg [7:0] cfg3_reg;
    reg [7:0] nonrem_reg;
    reg [7:0] sp_mask_reg;
    reg [7:0] bp_mask_reg;
    reg [7:0] budget_reg;

    // ------------------------------------------------------------------
    // Register select
    // ------------------------------------------------------------------
    localparam SEL_NONE = 5'h00;
    localparam SEL_CFG3 = 5'h01;
    localparam SEL_NONREM = 5'h02;
    localparam SEL_SP_MASK = 5'h04;
    localparam SEL_BP_MASK = 5'h08;
    localparam SEL_BUDGET = 5'h10;

    // One-hot select shared by the write and read paths, so both
    // always agree on which offsets exist
    function [4:0] reg_select;
        input [7:0] addr;
        begin
            case (addr)
                `OFS_CFG_BYTE3: reg_select = SEL_CFG3;
                `OFS_NON_REMOVABLE: reg_select = SEL_NONREM;
                `OFS_SELF_PWR_MASK: reg_select = SEL_SP_MASK;
                `OFS_BUS_PWR_MASK: reg_select = SEL_BP_MASK;
                `OFS_SELF_PWR_BUDGET: reg_select = SEL_BUDGET;
                default: reg_select = SEL_NONE;
            endcase
        end
    endfunction

    wire [4:0] reg_sel = reg_select(CFG_ADDR_I);

    // Register writes; all eight bits stored, reserved ones too
    // Writes to unmapped offsets change nothing
    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            cfg3_reg <= `RST_CFG_BYTE3;
            nonrem_reg <= `RST_NON_REMOVABLE;
            sp_mask_reg <= `RST_MASK;
            bp_mask_reg <= `RST_MASK;
            budget_reg <= `RST_BUDGET;
        end else if (CLK_EN_I && CFG_WR_I) begin
            case (reg_sel)
                SEL_CFG3: cfg3_reg <= CFG_WDATA_I;
                SEL_NONREM: nonrem_reg <= CFG_WDATA_I;
                SEL_SP_MASK: sp_mask_reg <= CFG_WDATA_I;
                SEL_BP_MASK: bp_mask_reg <= CFG_WDATA_I;
                SEL_BUDGET: budget_reg <= CFG_WDATA_I;
                default: cfg3_reg <= cfg3_reg;
            endcase
        end
    end

    // Read mux; unmapped offsets read zero
    // Combinational, so the address must stand while data is taken
    always @* begin
        case (reg_sel)
            SEL_CFG3: CFG_RDATA_O = cfg3_reg;
            SEL_NONREM: CFG_RDATA_O = nonrem_reg;
            SEL_SP_MASK: CFG_RDATA_O = sp_mask_reg;
            SEL_BP_MASK: CFG_RDATA_O = bp_mask_reg;
            SEL_BUDGET: CFG_RDATA_O = budget_reg;
            default: CFG_RDATA_O = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Disable selection
    // ------------------------------------------------------------------
    wire remap_en = cfg3_reg[`BIT_REMAP_EN];
    // Either strap pin of a port pulls it out of service
    wire [NPORT:1] strap_off = strap_pos | strap_neg;
    wire [NPORT:1] sp_bits = sp_mask_reg[NPORT:1];
    wire [NPORT:1] bp_bits = bp_mask_reg[NPORT:1];
    reg [NPORT:1] off_sel;

    // Mask follows the synchronised power mode; straps override regs
    // Remap mode hands port control elsewhere, so every port stays on
    always @* begin
        if (USE_DEFAULT_I)
            off_sel = strap_off;
        else if (self_pwr)
            off_sel = sp_bits;
        else
            off_sel = bp_bits;
        if (remap_en)
            off_sel = {NPORT{1'b0}};
    end

    // Port numbering is a separate combinational leaf
    // The count is three bits wide, which limits NPORT to seven
    wire [2:0] count_w;
    wire [3*NPORT-1:0] logical_w;
    port_renumber #(
        .NPORT(NPORT)
    ) u_renumber (
        .enabled_i(~off_sel),
        .count_o(count_w),
        .logical_o(logical_w)
    );

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    // Outputs registered so the hub core never sees decode glitches
    // Low clock enable holds every output but CFG_RDATA_O at its last value
    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            PORT_ENABLED_O <= {NPORT{1'b0}};
            PORT_COUNT_O <= 3'h0;
            PORT_LOGICAL_O <= {(3*NPORT){1'b0}};
            CURRENT_BUDGET_O <= `RST_BUDGET;
            COMPOUND_O <= 1'b0;
            REMAP_ACTIVE_O <= 1'b0;
        end else if (CLK_EN_I) begin
            PORT_ENABLED_O <= ~off_sel;
            PORT_COUNT_O <= count_w;
            PORT_LOGICAL_O <= logical_w;
            CURRENT_BUDGET_O <= budget_reg;
            // Any non-removable port marks a compound device
            COMPOUND_O <= |nonrem_reg[`PORT_HI:`PORT_LO];
            REMAP_ACTIVE_O <= remap_en;
        end
    end

endmodule // hub_port_disable_power_config

/* File: src/port_renumber.v */
// Maps the enabled physical ports onto contiguous logical numbers
module port_renumber #(
    parameter NPORT = 4
) (
    input wire [NPORT:1] enabled_i,
    output reg [2:0] count_o,
    output reg [3*NPORT-1:0] logical_o
);
    integer p;
    reg [2:0] next_num;

    // Walk ports low to high; each enabled port takes the next number
    always @* begin
        next_num = 3'h0;
        logical_o = {(3*NPORT){1'b0}};
        for (p = 1; p <= NPORT; p = p + 1) begin
            if (enabled_i[p]) begin
                next_num = next_num + 3'h1;
                logical_o[3*(p-1) +: 3] = next_num;
            end
        end
        count_o = next_num;
    end
endmodule // port_renumber

/* File: tb/hub_cfg_checker_asserts.sv */
// Checker for the hub port configuration block
`include "hub_port_cfg_defs.vh"
module hub_cfg_checker #(parameter NPORT = 4) (
    // Clock, reset and register port
    input wire CLK_SYS_I, RESETN_I, CLK_EN_I, CFG_WR_I, USE_DEFAULT_I,
    input wire [7:0] CFG_ADDR_I, CFG_WDATA_I, CFG_RDATA_O, CURRENT_BUDGET_O,
    // Straps and results
    input wire [NPORT:1] STRAP_POS_I, STRAP_NEG_I, PORT_ENABLED_O,
    input wire [2:0] PORT_COUNT_O,
    input wire [3*NPORT-1:0] PORT_LOGICAL_O,
    input wire COMPOUND_O, REMAP_ACTIVE_O
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESETN_I);
    // Write taken, then one edge without a strobe
    sequence wr_at(a);
        CLK_EN_I && CFG_WR_I && CFG_ADDR_I == a ##1 CLK_EN_I && !CFG_WR_I;
    endsequence
    AST_COUNT: assert property (
        PORT_COUNT_O == $countones(PORT_ENABLED_O))
        else $error("port count differs from enabled ports");
    AST_NUMBER: assert property (
        PORT_LOGICAL_O[2:0] == {2'b0, PORT_ENABLED_O[1]}
        && PORT_LOGICAL_O[3*NPORT-1 -: 3] ==
        (PORT_ENABLED_O[NPORT] ? PORT_COUNT_O : 3'h0))
        else $error("logical numbering not contiguous");
    AST_READBACK: assert property (wr_at(`OFS_SELF_PWR_MASK) |->
        CFG_ADDR_I != `OFS_SELF_PWR_MASK || CFG_RDATA_O == $past(CFG_WDATA_I))
        else $error("mask readback differs");
    AST_BUDGET: assert property (wr_at(`OFS_SELF_PWR_BUDGET) |=>
        CURRENT_BUDGET_O == $past(CFG_WDATA_I, 2))
        else $error("budget not updated");
    AST_REMAP: assert property (wr_at(`OFS_CFG_BYTE3) |=>
        REMAP_ACTIVE_O == $past(CFG_WDATA_I[`BIT_REMAP_EN], 2))
        else $error("remap flag not updated");
    AST_COMPOUND: assert property (wr_at(`OFS_NON_REMOVABLE) |=>
        COMPOUND_O == |$past(CFG_WDATA_I[4:1], 2))
        else $error("compound flag wrong");
    AST_MAP_ON: assert property (
        REMAP_ACTIVE_O && $past(REMAP_ACTIVE_O)
        |-> &PORT_ENABLED_O) else $error("mask applied while remapping");
    // Straps settle through the pin filter within six edges
    AST_STRAP: assert property ((USE_DEFAULT_I && !REMAP_ACTIVE_O &&
        $stable(STRAP_POS_I) && $stable(STRAP_NEG_I))[*6] |->
        PORT_ENABLED_O == ~(STRAP_POS_I | STRAP_NEG_I))
        else $error("strap disable wrong");
    cover property (wr_at(`OFS_SELF_PWR_MASK));
    cover property (PORT_COUNT_O == 3'h0);
    cover property (USE_DEFAULT_I && PORT_COUNT_O == 3'h2);
endmodule // hub_cfg_checker
bind hub_port_disable_power_config hub_cfg_checker #(.NPORT(NPORT)) chk_i (.*);

/* File: tb/hub_port_disable_power_config_test.sv */
// Testbench for the hub port disable and power configuration block
module hub_port_disable_power_config_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, wr = 0, use_def = 0, self_pwr = 1, ce = 1;
    logic [7:0] addr = 0, wdata = 0;
    logic [4:1] s_pos = 0, s_neg = 0;
    wire [7:0] rdata, budget;
    wire [4:1] en;
    wire [2:0] cnt, seen;
    wire [11:0] lg;
    wire compound, remap, b_ok;
    int n_errors = 0, num_checks = 0;
    always #20 clk = ~clk;
    hub_port_disable_power_config #(.NPORT(4)) uut (.CLK_SYS_I(clk),
        .RESETN_I(rst_n), .CLK_EN_I(ce), .CFG_ADDR_I(addr), .CFG_WR_I(wr),
        .CFG_WDATA_I(wdata), .CFG_RDATA_O(rdata), .USE_DEFAULT_I(use_def),
        .STRAP_POS_I(s_pos), .STRAP_NEG_I(s_neg), .SELF_POWERED_I(self_pwr),
        .PORT_ENABLED_O(en), .PORT_COUNT_O(cnt), .PORT_LOGICAL_O(lg),
        .CURRENT_BUDGET_O(budget), .COMPOUND_O(compound),
        .REMAP_ACTIVE_O(remap));
    usb_host_model host (.logical_i(lg), .budget_i(budget), .seen_o(seen),
        .budget_ok_o(b_ok));
    task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One strobe cycle, then two edges so the outputs follow
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1;
        @(negedge clk);
        wr = 0;
        repeat (2) @(negedge clk);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(negedge clk);
        addr = a;
        #1 chk("rdata", exp, rdata);
    endtask
    task automatic ports(logic [4:1] e, logic [2:0] c, logic [11:0] l);
        chk("enabled", e, en);
        chk("count", c, cnt);
        chk("logical", l, lg);
        chk("host ports", c, seen);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Pin changes pass a synchroniser and filter, so wait six edges
    task automatic pins;
        repeat (6) @(negedge clk);
    endtask
    // Outputs right after reset: all ports on, default budget
    task automatic test_reset;
        rd(8'h0c, 8'h32);
        rd(8'h0d, 8'h00);
        ports(4'hf, 3'd4, 12'h8d1);
        $display("reset test done");
    endtask
    // Self-powered mask: one port off, spare bits only, all off
    task automatic test_self_mask;
        wr_reg(8'h0a, 8'h02);
        ports(4'b1110, 3'd3, 12'h688);
        wr_reg(8'h0a, 8'he1);
        rd(8'h0a, 8'he1);
        ports(4'hf, 3'd4, 12'h8d1);
        wr_reg(8'h0a, 8'h1e);
        ports(4'h0, 3'd0, 12'h000);
        $display("self mask test done");
    endtask
    // Power mode picks the mask; remap enable overrides the self-powered one
    task automatic test_power_remap;
        self_pwr = 0;
        pins();
        wr_reg(8'h0b, 8'h10);
        ports(4'b0111, 3'd3, 12'h0d1);
        self_pwr = 1;
        pins();
        ports(4'h0, 3'd0, 12'h000);
        wr_reg(8'h08, 8'h08);
        chk("remap", 12'h001, remap);
        ports(4'hf, 3'd4, 12'h8d1);
        wr_reg(8'h08, 8'h00);
        chk("remap", 12'h000, remap);
        wr_reg(8'h0a, 8'h00);
        $display("power mode and remap test done");
    endtask
    // Straps pick the disabled ports in both power modes
    task automatic test_straps;
        s_pos = 4'b0001;
        s_neg = 4'b1000;
        use_def = 1;
        pins();
        ports(4'b0110, 3'd2, 12'h088);
        s_pos = 4'b0100;
        s_neg = 4'b0010;
        self_pwr = 0;
        pins();
        ports(4'b1001, 3'd2, 12'h401);
        // Hold the straps long enough for the checker to judge them
        pins();
        self_pwr = 1;
        use_def = 0;
        $display("strap test done");
    endtask
    // Budget, compound flag, then a write held off by the enable
    task automatic test_budget;
        wr_reg(8'h0c, 8'h19);
        chk("budget", 12'h019, budget);
        chk("budget ok", 12'h001, b_ok);
        wr_reg(8'h09, 8'h04);
        chk("compound", 12'h001, compound);
        ce = 0;
        wr_reg(8'h0c, 8'h7f);
        ce = 1;
        rd(8'h0c, 8'h19);
        chk("budget", 12'h019, budget);
        $display("budget and enable test done");
    endtask
    // Main sequence: reset, then one scenario after another
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1;
        repeat (2) @(negedge clk);
        test_reset();
        test_self_mask();
        test_power_remap();
        test_straps();
        test_budget();
        end_sim();
    end
    // Watchdog well beyond the 79 or so cycles the tests need
    initial begin
        #40000;
        n_errors++;
        end_sim();
    end
endmodule // hub_port_disable_power_config_test

/* File: tb/usb_host_model.sv */
// Upstream host model that enumerates the ports the hub offers
module usb_host_model (
    input wire [11:0] logical_i,
    input wire [7:0] budget_i,
    output logic [2:0] seen_o,
    output logic budget_ok_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Embedded peripheral declares no current; the hub value covers it
    localparam int PERIPH_MA = 0;
    // Only ports given a logical number can be enumerated
    always_comb begin
        seen_o = 3'h0;
        for (int p = 0; p < 4; p++)
            seen_o = seen_o + {2'b0, logical_i[3*p +: 3] != 3'h0};
    end
    // Whole budget must stay within 100 mA, i.e. 50 units
    assign budget_ok_o = (budget_i + PERIPH_MA) <= 50;
endmodule // usb_host_model
